// ===== core/slcfg_pkg.sv
// constants and types shared by the serial link configuration block
package slcfg_pkg;

  // ****************************************************************
  // register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [11:0] LINK_ENABLE_IDX = 12'h200;
  localparam logic [11:0] LINK_MODE_IDX = 12'h201;
  localparam logic [11:0] SW_SYNC_IDX = 12'h203;
  localparam logic [11:0] LINK_CONTROL_IDX = 12'h204;
  localparam logic [11:0] LINK_TEST_SELECT_IDX = 12'h205;
  localparam logic [11:0] LINK_IDENT_VALUE_IDX = 12'h206;
  localparam logic [11:0] FRAME_END_CHAR_IDX = 12'h207;
  localparam logic [11:0] LINK_STATUS_IDX = 12'h20f;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] LINK_ENABLE_RST = 8'h01;
  localparam logic [7:0] LINK_MODE_RST = 8'h00;
  localparam logic [7:0] SW_SYNC_RST = 8'h01;
  localparam logic [7:0] LINK_CONTROL_RST = 8'h03;
  localparam logic [7:0] LINK_TEST_SELECT_RST = 8'h00;
  localparam logic [7:0] LINK_IDENT_VALUE_RST = 8'h00;
  localparam logic [7:0] FRAME_END_CHAR_RST = 8'h00;

  // ****************************************************************
  // field positions and widths
  // ****************************************************************
  localparam int CTRL_SCRAMBLE_BIT = 0;
  localparam int CTRL_FORMAT_BIT = 1;
  localparam int CTRL_SYNC_LSB = 2;
  localparam int CTRL_UPPER_BIT = 4;
  localparam int CTRL_USED_BITS = 5;
  localparam int TEST_USED_BITS = 5;
  localparam int MODE_USED_BITS = 6;
  localparam int FRAME_END_CHAR_SELECT_USED_BITS = 2;
  localparam int LANE_BASE_UPPER = 4;
  localparam int LANE_UPPER_MAX = 4;

  // ****************************************************************
  // sync source codes
  // ****************************************************************
  localparam logic [1:0] SYNC_FROM_PIN = 2'h0;
  localparam logic [1:0] SYNC_FROM_TIMESTAMP = 2'h1;
  localparam logic [1:0] SYNC_FROM_SOFTWARE = 2'h2;

  // ****************************************************************
  // test pattern codes
  // ****************************************************************
  typedef enum logic [4:0] {
    PAT_NORMAL = 5'h00, PAT_PRBS7 = 5'h01, PAT_PRBS15 = 5'h02,
    PAT_PRBS23 = 5'h03, PAT_RAMP = 5'h04, PAT_TRANSPORT = 5'h05,
    PAT_D21_5 = 5'h06, PAT_K28_5 = 5'h07, PAT_ILA_REPEAT = 5'h08,
    PAT_RPAT = 5'h09, PAT_HOLD_LOW = 5'h0a, PAT_HOLD_HIGH = 5'h0b,
    PAT_PRBS9 = 5'h0d, PAT_PRBS31 = 5'h0e, PAT_CLOCK = 5'h0f,
    PAT_K28_7 = 5'h10
  } slcfg_pattern_t;

  localparam logic [30:0] PRBS_SEED = 31'h7fffffff;
  localparam logic [3:0] CLOCK_HALF_LEN = 4'h8;

endpackage

// ===== core/slcfg_link_config.sv
// register bank and control decode for the serial transmit link
`timescale 1ns/10ps
// How it works
// - with upper lanes off, data uses lanes zero to lane count minus one.
// - with upper lanes on and at most four lanes, data uses lanes four up.
// - sync source code 0 is the pin, 1 the timestamp input, 2 software only.
// - the format bit gives offset binary at 0, two's complement at 1.
// - in 8b10b modes the scrambler follows its enable bit, reset on.
// - in 64b66b modes the payload is always scrambled.
// - test codes 0 to 4 are normal, prbs7, prbs15, prbs23 and ramp.
// - codes 5 to 11 are the fixed patterns and held levels, 12 reserved.
// - codes 13 to 16 are prbs9, prbs31, clock and k28.7, rest reserved.
// - k28.5, ila repeat, rpat and k28.7 exist only in 8b10b modes.
// - the identifier register is sent in the alignment sequence, reset 0.
// - a cleared link enable holds link logic in reset and powers down.
// - writing 0 to the software sync bit requests sync, 1 releases it.
module slcfg_link_config
  import slcfg_pkg::*;
#(
  parameter int LANES = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] modeLaneCount,
  input wire logic modeIs8b10b,
  input wire logic singleEndedSyncPinN,
  input wire logic timestampDiffInputN,
  input wire logic timestampReceiverEnable,
  output logic [5:0] linkOutputMode,
  output logic [LANES-1:0] laneActive,
  output logic linkReset,
  output logic serializerPowerDown,
  output logic syncRequest,
  output logic sampleTwosComplement,
  output logic scramblerActive,
  output logic [4:0] linkTestPatternSelect,
  output logic testPatternValid,
  output logic testSerialBit,
  output logic [7:0] linkDeviceIdentifier,
  output logic [1:0] frameEndCharacterSelect
);

  if (LANES != 8) begin : g_lane_check
    $error("slcfg_link_config serves eight lanes only");
  end

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire logic [11:0] regIdx = paddr[13:2];
  wire logic setupPhase = psel && !penable;
  wire logic accessPhase = psel && penable;
  wire logic hitEnable = regIdx == LINK_ENABLE_IDX;
  wire logic hitMode = regIdx == LINK_MODE_IDX;
  wire logic hitSync = regIdx == SW_SYNC_IDX;
  wire logic hitControl = regIdx == LINK_CONTROL_IDX;
  wire logic hitTest = regIdx == LINK_TEST_SELECT_IDX;
  wire logic hitIdent = regIdx == LINK_IDENT_VALUE_IDX;
  wire logic hitFchar = regIdx == FRAME_END_CHAR_IDX;
  wire logic hitStatus = regIdx == LINK_STATUS_IDX;
  wire logic mapped = hitEnable || hitMode || hitSync || hitControl ||
                      hitTest || hitIdent || hitFchar || hitStatus;
  wire logic wrStrobe = accessPhase && pwrite && mapped;

  assign pready = 1'b1;
  assign pslverr = accessPhase && !mapped;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] linkEnable_q;
  logic [7:0] linkMode_q;
  logic [7:0] swSync_q;
  logic [7:0] linkControl_q;
  logic [7:0] testSelect_q;
  logic [7:0] identValue_q;
  logic [7:0] frameChar_q;
  logic [31:0] prdata_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      linkEnable_q <= LINK_ENABLE_RST;
      linkMode_q <= LINK_MODE_RST;
      swSync_q <= SW_SYNC_RST;
      linkControl_q <= LINK_CONTROL_RST;
      testSelect_q <= LINK_TEST_SELECT_RST;
      identValue_q <= LINK_IDENT_VALUE_RST;
      frameChar_q <= FRAME_END_CHAR_RST;
    end else if (wrStrobe) begin
      if (hitEnable) linkEnable_q <= {7'h00, pwdata[0]};
      if (hitMode) linkMode_q <= {2'h0, pwdata[MODE_USED_BITS-1:0]};
      if (hitSync) swSync_q <= {7'h00, pwdata[0]};
      if (hitControl) linkControl_q <= {3'h0, pwdata[CTRL_USED_BITS-1:0]};
      if (hitTest) testSelect_q <= {3'h0, pwdata[TEST_USED_BITS-1:0]};
      if (hitIdent) identValue_q <= pwdata[7:0];
      if (hitFchar) frameChar_q <= {6'h00, pwdata[FRAME_END_CHAR_SELECT_USED_BITS-1:0]};
    end
  end

  // ****************************************************************
  // control decode
  // ****************************************************************
  wire logic linkOn = linkEnable_q[0];
  wire logic upperLanes = linkControl_q[CTRL_UPPER_BIT];
  wire logic [1:0] syncSource = linkControl_q[CTRL_SYNC_LSB +: 2];
  wire logic [4:0] testCode = testSelect_q[4:0];

  // requires the 8b10b coding
  function automatic logic needs8b10b(input logic [4:0] code);
    needs8b10b = code == PAT_K28_5 || code == PAT_ILA_REPEAT ||
                 code == PAT_RPAT || code == PAT_K28_7;
  endfunction

  // codes with a defined pattern
  function automatic logic knownCode(input logic [4:0] code);
    knownCode = code <= PAT_HOLD_HIGH ||
                (code >= PAT_PRBS9 && code <= PAT_K28_7);
  endfunction

  // prbs feedback: x7+x6, x9+x5, x15+x14, x23+x18, x31+x28
  function automatic logic prbsFeedback(input logic [4:0] code,
                                         input logic [30:0] s);
    unique case (code)
      PAT_PRBS7: prbsFeedback = s[6] ^ s[5];
      PAT_PRBS9: prbsFeedback = s[8] ^ s[4];
      PAT_PRBS15: prbsFeedback = s[14] ^ s[13];
      PAT_PRBS23: prbsFeedback = s[22] ^ s[17];
      default: prbsFeedback = s[30] ^ s[27];
    endcase
  endfunction

  wire logic isPrbs = testCode == PAT_PRBS7 || testCode == PAT_PRBS9 ||
                      testCode == PAT_PRBS15 || testCode == PAT_PRBS23 ||
                      testCode == PAT_PRBS31;
  wire logic patternOk = knownCode(testCode) &&
                         (modeIs8b10b || !needs8b10b(testCode));

  // ****************************************************************
  // lane placement
  // ****************************************************************
  wire logic [LANES-1:0] lowMask;
  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++) begin : g_lane
      assign lowMask[gi] = 4'(gi) < modeLaneCount;
    end
  endgenerate
  wire logic upperOk = modeLaneCount <= 4'(LANE_UPPER_MAX);
  wire logic [LANES-1:0] laneMask_d =
    !linkOn ? '0 :
    (upperLanes && upperOk) ? LANES'(lowMask << LANE_BASE_UPPER) :
    lowMask;

  // ****************************************************************
  // sync request sources
  // ****************************************************************
  logic pinMeta_q;
  logic pinSync_q;
  logic tsMeta_q;
  logic tsSync_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pinMeta_q <= 1'b1;
      pinSync_q <= 1'b1;
      tsMeta_q <= 1'b1;
      tsSync_q <= 1'b1;
    end else begin
      pinMeta_q <= singleEndedSyncPinN;
      pinSync_q <= pinMeta_q;
      tsMeta_q <= timestampDiffInputN;
      tsSync_q <= tsMeta_q;
    end
  end

  // timestamp input only counts with its receiver on
  wire logic tsRequest = !tsSync_q && timestampReceiverEnable;
  wire logic pinRequest =
    (syncSource == SYNC_FROM_PIN && !pinSync_q) ||
    (syncSource == SYNC_FROM_TIMESTAMP && tsRequest);
  wire logic syncRequest_d = linkOn && (!swSync_q[0] || pinRequest);

  // ****************************************************************
  // pattern generator
  // ****************************************************************
  logic [30:0] prbs_q;
  logic [3:0] clockCount_q;
  logic clockLevel_q;
  logic [4:0] lastCode_q;
  wire logic restartPattern = !linkOn || testCode != lastCode_q;
  wire logic prbsNext = prbsFeedback(testCode, prbs_q);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prbs_q <= PRBS_SEED;
      clockCount_q <= '0;
      clockLevel_q <= 1'b0;
      lastCode_q <= '0;
    end else begin
      lastCode_q <= testCode;
      if (restartPattern) begin
        prbs_q <= PRBS_SEED;
        clockCount_q <= '0;
        clockLevel_q <= 1'b0;
      end else begin
        if (isPrbs) prbs_q <= {prbs_q[29:0], prbsNext};
        if (clockCount_q == CLOCK_HALF_LEN - 4'h1) begin
          clockCount_q <= '0;
          clockLevel_q <= !clockLevel_q;
        end else begin
          clockCount_q <= clockCount_q + 4'h1;
        end
      end
    end
  end

  wire logic testBit_d =
    !linkOn || !patternOk ? 1'b0 :
    isPrbs ? prbsNext :
    testCode == PAT_CLOCK ? clockLevel_q :
    testCode == PAT_HOLD_HIGH;

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  logic [LANES-1:0] laneActive_q;
  logic syncRequest_q;
  logic scramble_q;
  logic testBit_q;
  logic patternValid_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      laneActive_q <= '0;
      syncRequest_q <= 1'b0;
      scramble_q <= 1'b0;
      testBit_q <= 1'b0;
      patternValid_q <= 1'b0;
    end else begin
      laneActive_q <= laneMask_d;
      syncRequest_q <= syncRequest_d;
      scramble_q <= !modeIs8b10b || linkControl_q[CTRL_SCRAMBLE_BIT];
      testBit_q <= testBit_d;
      patternValid_q <= linkOn && patternOk;
    end
  end

  assign laneActive = laneActive_q;
  assign syncRequest = syncRequest_q;
  assign scramblerActive = scramble_q;
  assign testSerialBit = testBit_q;
  assign testPatternValid = patternValid_q;
  assign linkReset = !linkOn;
  assign serializerPowerDown = !linkOn;
  assign sampleTwosComplement = linkControl_q[CTRL_FORMAT_BIT];
  assign linkTestPatternSelect = testCode;
  assign linkDeviceIdentifier = identValue_q;
  assign frameEndCharacterSelect = frameChar_q[1:0];
  assign linkOutputMode = linkMode_q[5:0];

  // ****************************************************************
  // read data
  // ****************************************************************
  wire logic [7:0] statusWord = {3'h0, patternValid_q, scramble_q,
                                 syncRequest_q, upperOk, linkOn};
  wire logic [7:0] readByte =
    hitEnable ? linkEnable_q :
    hitMode ? linkMode_q :
    hitSync ? swSync_q :
    hitControl ? linkControl_q :
    hitTest ? testSelect_q :
    hitIdent ? identValue_q :
    hitFchar ? frameChar_q :
    hitStatus ? statusWord : 8'h00;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) prdata_q <= '0;
    else if (setupPhase && !pwrite) prdata_q <= {24'h000000, readByte};
  end
  assign prdata = prdata_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_sync_write(logic v);
    wrStrobe && hitSync && pwdata[0] == v;
  endsequence
  sequence s_link_held;
    linkOn && swSync_q[0] && !pinRequest;
  endsequence

  a_low_lanes: assert property (
    linkOn && !upperLanes |=> laneActive == $past(lowMask))
    else $error("low lane mask wrong");
  a_upper_lanes: assert property (
    linkOn && upperLanes && upperOk |=>
      laneActive[3:0] == 4'h0 && laneActive[7:4] == $past(lowMask[3:0]))
    else $error("upper lane mask wrong");
  a_sync_source: assert property (
    linkOn && swSync_q[0] && syncSource == SYNC_FROM_SOFTWARE
      |=> !syncRequest)
    else $error("pin sync leaked in software mode");
  a_ts_gate: assert property (
    linkOn && swSync_q[0] && syncSource == SYNC_FROM_TIMESTAMP &&
      !timestampReceiverEnable |=> !syncRequest)
    else $error("timestamp sync without receiver enable");
  a_format_bit: assert property (
    wrStrobe && hitControl |=>
      sampleTwosComplement == $past(pwdata[CTRL_FORMAT_BIT]))
    else $error("format bit not taken");
  a_scramble_8b: assert property (
    modeIs8b10b && !linkControl_q[CTRL_SCRAMBLE_BIT] |=> !scramblerActive)
    else $error("scrambler on while disabled");
  a_scramble_64b: assert property (
    !modeIs8b10b |=> scramblerActive)
    else $error("64b66b payload not scrambled");
  a_pattern_8b: assert property (
    !modeIs8b10b && needs8b10b(testCode) |=> !testPatternValid)
    else $error("8b10b pattern offered in 64b66b");
  a_reserved_code: assert property (
    testCode == 5'h0c || testCode > PAT_K28_7 |=> !testPatternValid)
    else $error("reserved test code accepted");
  a_hold_levels: assert property (
    linkOn && patternOk && testCode == PAT_HOLD_HIGH ##1
      testCode == PAT_HOLD_HIGH |-> testSerialBit)
    else $error("held high output not high");
  a_ident_value: assert property (
    wrStrobe && hitIdent |=> linkDeviceIdentifier == $past(pwdata[7:0]))
    else $error("identifier not stored");
  a_disable_reset: assert property (
    !linkOn |=> laneActive == '0 && !syncRequest && !testPatternValid)
    else $error("link active while disabled");
  a_sw_sync: assert property (
    s_sync_write(1'b0) ##1 linkOn && !swSync_q[0] |=> syncRequest)
    else $error("software sync not raised");
  a_sw_release: assert property (
    s_sync_write(1'b1) ##1 s_link_held |=> !syncRequest)
    else $error("software sync not released");
  a_prbs_run: assert property (
    linkOn && isPrbs && !restartPattern |=> prbs_q != $past(prbs_q))
    else $error("prbs stalled");

endmodule // slcfg_link_config

// ===== test/slcfg_link_receiver_model.sv
// far-end receiver model driving the active-low sync request pins
`timescale 1ns/10ps
module slcfg_link_receiver_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic seRequest,
  input wire logic tsRequest,
  output logic singleEndedSyncPinN,
  output logic timestampDiffInputN
);
  // pins idle high, pulled low while a request is held
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      singleEndedSyncPinN <= 1'b1;
      timestampDiffInputN <= 1'b1;
    end else begin
      singleEndedSyncPinN <= !seRequest;
      timestampDiffInputN <= !tsRequest;
    end
  end
endmodule // slcfg_link_receiver_model

// ===== test/tb_slcfg_link_config.sv
// self-checking bench for the serial link configuration block
`timescale 1ns/10ps
module tb_slcfg_link_config;
  import slcfg_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] modeLaneCount = 4'h2;
  logic modeIs8b10b = 1'b1;
  logic tsEnable = 1'b0;
  logic seRequest = 1'b0;
  logic tsRequest = 1'b0;
  wire logic sePinN;
  wire logic tsPinN;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] laneActive;
  logic linkReset;
  logic powerDown;
  logic syncRequest;
  logic sampleTwos;
  logic scramblerActive;
  logic [4:0] patSel;
  logic patValid;
  logic testSerialBit;
  logic [7:0] devId;
  logic [5:0] linkMode;
  logic [1:0] frame_end_char_select;
  logic [31:0] rdata;
  logic rerr;
  logic prbs [254];
  int badCount = 0;
  int checkCount = 0;
  int k;
  logic [11:0] rIdx [7] = '{LINK_ENABLE_IDX, LINK_MODE_IDX, SW_SYNC_IDX,
    LINK_CONTROL_IDX, LINK_TEST_SELECT_IDX, LINK_IDENT_VALUE_IDX,
    FRAME_END_CHAR_IDX};
  logic [7:0] rRst [7] = '{8'h01, 8'h00, 8'h01, 8'h03, 8'h00, 8'h00, 8'h00};
  logic [7:0] rMask [7] = '{8'h01, 8'h3f, 8'h01, 8'h1f, 8'h1f, 8'hff, 8'h03};

  always #5 clock = ~clock;

  slcfg_link_config #(.LANES(8)) i_slcfg_link_config (.clock(clock),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .modeLaneCount(modeLaneCount),
    .modeIs8b10b(modeIs8b10b), .singleEndedSyncPinN(sePinN),
    .timestampDiffInputN(tsPinN), .timestampReceiverEnable(tsEnable),
    .linkOutputMode(linkMode), .laneActive(laneActive),
    .linkReset(linkReset),
    .serializerPowerDown(powerDown), .syncRequest(syncRequest),
    .sampleTwosComplement(sampleTwos), .scramblerActive(scramblerActive),
    .linkTestPatternSelect(patSel), .testPatternValid(patValid),
    .testSerialBit(testSerialBit), .linkDeviceIdentifier(devId),
    .frameEndCharacterSelect(frame_end_char_select));

  slcfg_link_receiver_model i_slcfg_link_receiver_model (.clock(clock),
    .resetn(resetn), .seRequest(seRequest), .tsRequest(tsRequest),
    .singleEndedSyncPinN(sePinN), .timestampDiffInputN(tsPinN));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic tallyAndFinish();
    $display("mismatches %0d checks %0d", badCount, checkCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic checkBit(input logic got, input logic exp);
    checkVal({31'h0, got}, {31'h0, exp});
  endtask

  task automatic apb(input logic w, input logic [11:0] i,
                     input logic [31:0] d);
    int n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      badCount++;
      tallyAndFinish();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    apb(1'b1, i, {24'h0, d});
  endtask

  task automatic rd(input logic [11:0] i, input logic [7:0] e);
    apb(1'b0, i, 32'h0);
    checkVal(rdata, {24'h0, e});
  endtask

  // change a field with the link held off
  task automatic cfg(input logic [11:0] i, input logic [7:0] d);
    wr(LINK_ENABLE_IDX, 8'h00);
    wr(i, d);
    wr(LINK_ENABLE_IDX, 8'h01);
    repeat (2) @(posedge clock);
  endtask

  task automatic ones(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clock);
      c += (testSerialBit === 1'b1);
    end
  endtask

  task automatic syncCase(input logic [7:0] c, input logic s, t, e, x);
    cfg(LINK_CONTROL_IDX, c);
    seRequest <= s;
    tsRequest <= t;
    tsEnable <= e;
    repeat (5) @(posedge clock);
    checkBit(syncRequest, x);
    seRequest <= 1'b0;
    tsRequest <= 1'b0;
  endtask

  function automatic logic expValid(input int c, input logic m);
    return c <= 16 && c != 12 && (m || !(c inside {7, 8, 9, 16}));
  endfunction

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    checkBit(sampleTwos, 1'b1);
    checkBit(scramblerActive, 1'b1);
    checkVal({24'h0, laneActive}, 32'h03);
    for (int i = 0; i < 7; i++) begin
      rd(rIdx[i], rRst[i]);
    end
    wr(LINK_ENABLE_IDX, 8'h00);
    repeat (2) @(posedge clock);
    checkBit(linkReset, 1'b1);
    checkBit(powerDown, 1'b1);
    checkVal({24'h0, laneActive}, 32'h0);
    for (int i = 1; i < 7; i++) begin
      wr(rIdx[i], 8'hff);
      rd(rIdx[i], rMask[i]);
      wr(rIdx[i], rRst[i]);
    end
    cfg(LINK_IDENT_VALUE_IDX, 8'ha5);
    checkVal({24'h0, devId}, 32'ha5);
    checkBit(linkReset, 1'b0);
    checkBit(powerDown, 1'b0);
    cfg(LINK_MODE_IDX, 8'h2a);
    checkVal({26'h0, linkMode}, 32'h2a);
    cfg(FRAME_END_CHAR_IDX, 8'h02);
    checkVal({30'h0, frame_end_char_select}, 32'h2);
    cfg(LINK_CONTROL_IDX, 8'h13);
    checkVal({24'h0, laneActive}, 32'h30);
    modeLaneCount <= 4'h4;
    cfg(LINK_CONTROL_IDX, 8'h13);
    checkVal({24'h0, laneActive}, 32'hf0);
    cfg(LINK_CONTROL_IDX, 8'h03);
    checkVal({24'h0, laneActive}, 32'h0f);
    cfg(LINK_CONTROL_IDX, 8'h00);
    checkBit(sampleTwos, 1'b0);
    checkBit(scramblerActive, 1'b0);
    modeIs8b10b <= 1'b0;
    repeat (2) @(posedge clock);
    checkBit(scramblerActive, 1'b1);
    modeIs8b10b <= 1'b1;
    syncCase(8'h03, 1'b1, 1'b0, 1'b0, 1'b1);
    syncCase(8'h03, 1'b0, 1'b1, 1'b1, 1'b0);
    syncCase(8'h07, 1'b0, 1'b1, 1'b0, 1'b0);
    syncCase(8'h07, 1'b1, 1'b1, 1'b1, 1'b1);
    syncCase(8'h0b, 1'b1, 1'b1, 1'b1, 1'b0);
    wr(SW_SYNC_IDX, 8'h00);
    repeat (2) @(posedge clock);
    checkBit(syncRequest, 1'b1);
    wr(SW_SYNC_IDX, 8'h01);
    repeat (2) @(posedge clock);
    checkBit(syncRequest, 1'b0);
    for (int m = 0; m < 2; m++) begin
      modeIs8b10b <= m[0];
      for (int c = 1; c < 32; c++) begin
        cfg(LINK_TEST_SELECT_IDX, c[7:0]);
        checkVal({27'h0, patSel}, c);
        checkBit(patValid, expValid(c, m[0]));
      end
    end
    cfg(LINK_TEST_SELECT_IDX, 8'h0a);
    ones(8, k);
    checkVal(32'(k), 32'h0);
    cfg(LINK_TEST_SELECT_IDX, 8'h0b);
    ones(8, k);
    checkVal(32'(k), 32'h8);
    cfg(LINK_TEST_SELECT_IDX, 8'h0f);
    ones(16, k);
    checkVal(32'(k), 32'h8);
    cfg(LINK_TEST_SELECT_IDX, 8'h01);
    for (int i = 0; i < 254; i++) begin
      @(posedge clock);
      prbs[i] = testSerialBit;
    end
    k = 0;
    for (int i = 0; i < 127; i++) begin
      k += (prbs[i] !== prbs[i+127]) + 256 * (prbs[i] === 1'b1);
    end
    checkVal(32'(k), 32'd16384);
    cfg(LINK_TEST_SELECT_IDX, 8'h00);
    ones(8, k);
    checkVal(32'(k), 32'h0);
    rd(LINK_STATUS_IDX, 8'h1b);
    apb(1'b0, 12'h300, 32'h0);
    checkBit(rerr, 1'b1);
    checkVal(rdata, 32'h0);
    apb(1'b1, 12'h300, 32'hff);
    checkBit(rerr, 1'b1);
    tallyAndFinish();
  end
endmodule // tb_slcfg_link_config
